// ---- rtl/memory_access_port_pkg.sv ----
package memory_access_port_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_DAR_LAST = 12'h3FC;
  localparam logic [11:0] OFF_CSW      = 12'hD00;
  localparam logic [11:0] OFF_TAR_LO   = 12'hD04;
  localparam logic [11:0] OFF_TAR_HI   = 12'hD08;
  localparam logic [11:0] OFF_DRW      = 12'hD0C;
  localparam logic [11:0] OFF_BD_FIRST = 12'hD10;
  localparam logic [11:0] OFF_BD_LAST  = 12'hD1C;
  localparam logic [11:0] OFF_MBT      = 12'hD20;
  localparam logic [11:0] OFF_TRR      = 12'hD24;
  localparam logic [11:0] OFF_BASE_HI  = 12'hDF0;
  localparam logic [11:0] OFF_CFG      = 12'hDF4;
  localparam logic [11:0] OFF_BASE_LO  = 12'hDF8;
  localparam logic [11:0] OFF_IDR      = 12'hDFC;

  // ---------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------
  localparam int ACCESS_SIZE_FIELD_LSB = 0;
  localparam int CSW_INC_LSB  = 4;
  localparam int CSW_BUSY_BIT = 7;
  localparam int CSW_MODE_LSB = 8;
  localparam int CFG_BE_BIT   = 0;
  localparam int CFG_LA_BIT   = 1;
  localparam int CFG_LD_BIT   = 2;
  localparam int TRR_ERR_BIT  = 0;
  localparam int WORD_W       = 32;
  localparam int ADDR_W       = 64;
  localparam int BUS_DW       = 256;

  // ---------------------------------------------------------------
  // Encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] SZ_WORD  = 3'h2;
  localparam logic [2:0] SZ_DWORD = 3'h3;
  localparam logic [2:0] SZ_QWORD = 3'h4;
  localparam logic [2:0] SZ_OWORD = 3'h5;
  localparam logic [1:0] INC_OFF  = 2'h0;
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [7:0] NARROW_SIZES = 8'h07;

  typedef enum logic [1:0] {
    CMP_NONE   = 2'h0,
    CMP_VERIFY = 2'h1,
    CMP_FIND   = 2'h2
  } cmp_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUS  = 3'b010,
    ST_CMP  = 3'b100
  } state_t;

  function automatic logic [2:0] last_beat_of(input logic [2:0] sz);
    case (sz)
      SZ_DWORD: return 3'h1;
      SZ_QWORD: return 3'h3;
      SZ_OWORD: return 3'h7;
      default:  return 3'h0;
    endcase
  endfunction

endpackage

// ---- rtl/memory_access_port_core.sv ----
`timescale 1ns/1ps
// Operation
// - Wide addressing gives 64-bit transfer address
// - Wide data offers 64 to 256-bit sizes
// - Unsupported size write reads back supported size
// - Bus uses the size that reads back
// - Wide transfers span consecutive 32-bit data accesses
// - Barrier request orders surrounding bus accesses
// - Verify write reads, mismatch sets compare flag
// - Verify advances address whether or not matched
// - Find match sets flag, mismatch advances address
// - Find compares only selected byte lanes
// - Without increment find polls one location
// - Nonzero repeat count repeats find reads
// - Counted read increments address, decrements counter
// - Counted search stops on match or zero
// - Reserved offsets read zero, ignore writes
// - Transfer address low word, high or zero
// - No barrier extension makes barrier reserved
// - Base pointer low word, optional high word
module memory_access_port_core
  import memory_access_port_pkg::*;
#(
  parameter bit          HAS_WIDE_ADDR = 1'b1,
  parameter bit          HAS_WIDE_DATA = 1'b1,
  parameter bit          HAS_BARRIER   = 1'b1,
  parameter logic [7:0]  SIZE_SUPPORT  = 8'h3F,
  parameter int          CNT_W         = 12,
  parameter logic [31:0] ROOT_LO       = 32'h0000_0003,
  parameter logic [31:0] ROOT_HI       = 32'h0000_0000,
  // Arbitrary identification value
  parameter logic [31:0] IDENT         = 32'h0000_0000
) (
  input  wire logic              CORE_CLK,
  input  wire logic              RST,
  input  wire logic              AP_REQ,
  input  wire logic              AP_WRITE,
  input  wire logic [11:0]       AP_ADDR,
  input  wire logic [31:0]       AP_WDATA,
  input  wire cmp_t              AP_CMP_MODE,
  input  wire logic [3:0]        AP_BYTE_MASK,
  input  wire logic [CNT_W-1:0]  REPEAT_COUNT,
  output logic                   AP_ACK,
  output logic [31:0]            AP_RDATA,
  output logic                   CMP_SET,
  output logic                   REPEAT_DEC,
  output logic                   MEM_REQ,
  output logic                   MEM_WRITE,
  output logic                   MEM_BARRIER,
  output logic [ADDR_W-1:0]      MEM_ADDR,
  output logic [2:0]             MEM_SIZE,
  output logic [BUS_DW-1:0]      MEM_WDATA,
  input  wire logic [BUS_DW-1:0] MEM_RDATA,
  input  wire logic              MEM_ACK,
  input  wire logic              MEM_ERR
);

  localparam logic [7:0] SUP = HAS_WIDE_DATA ? SIZE_SUPPORT
                                             : (SIZE_SUPPORT & NARROW_SIZES);
  localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  state_t              st_r;
  logic [2:0]          size_r;
  logic [1:0]          inc_r;
  logic [3:0]          mode_r;
  logic [ADDR_W-1:0]   tar_r;
  logic                trr_err_r;
  logic [2:0]          beat_r;
  logic [BUS_DW-1:0]   wbuf_r;
  logic [BUS_DW-1:0]   rbuf_r;
  logic [31:0]         cmp_val_r;
  logic [31:0]         cmp_mask_r;
  logic                find_r;
  logic                drw_r;
  logic [CNT_W-1:0]    cnt_r;
  logic                ack_r;
  logic [31:0]         rdata_r;
  logic                cmp_set_r;
  logic                dec_r;
  logic                mem_req_r;
  logic                mem_write_r;
  logic                mem_bar_r;
  logic [ADDR_W-1:0]   mem_addr_r;
  logic [BUS_DW-1:0]   mem_wdata_r;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic              take, is_dar, is_drw, is_bd, is_data, is_mbt;
  logic              last_beat, inc_on, match;
  logic              t_cmp, t_wr_bus, t_rd_bus, t_bar, t_bus, t_local;
  logic              bus_done, cmp_evt, cmp_finish, reissue;
  logic [ADDR_W-1:0] data_addr, inc_bytes, tar_step;
  logic [BUS_DW-1:0] wbuf_nxt;
  logic [31:0]       lane_mask, csw_rd, cfg_rd, reg_rd;

  assign take    = AP_REQ && (st_r == ST_IDLE) && !ack_r;
  assign is_dar  = AP_ADDR <= OFF_DAR_LAST;
  assign is_drw  = AP_ADDR == OFF_DRW;
  assign is_bd   = (AP_ADDR >= OFF_BD_FIRST) && (AP_ADDR <= OFF_BD_LAST);
  assign is_data = is_dar || is_drw || is_bd;
  assign is_mbt  = HAS_BARRIER && (AP_ADDR == OFF_MBT);

  assign last_beat = beat_r == last_beat_of(size_r);
  assign inc_on    = inc_r != INC_OFF;
  assign inc_bytes = {{(ADDR_W-1){1'b0}}, 1'b1} << size_r;
  assign tar_step  = inc_on ? inc_bytes : '0;

  always_comb begin
    if (is_drw) begin
      data_addr = tar_r;
    end else if (is_bd) begin
      data_addr = {tar_r[ADDR_W-1:4], AP_ADDR[3:2], 2'b00};
    end else begin
      data_addr = {tar_r[ADDR_W-1:10], AP_ADDR[9:2], 2'b00};
    end
  end

  always_comb begin
    wbuf_nxt = wbuf_r;
    wbuf_nxt[{beat_r, 5'b00000} +: WORD_W] = AP_WDATA;
  end

  // Per-lane compare mask
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign lane_mask[b*8 +: 8] = {8{AP_BYTE_MASK[b]}};
  end

  assign match = ((MEM_RDATA[WORD_W-1:0] ^ cmp_val_r) & cmp_mask_r) == '0;

  assign t_cmp    = take && is_data && AP_WRITE && (AP_CMP_MODE != CMP_NONE);
  assign t_wr_bus = take && is_data && AP_WRITE && (AP_CMP_MODE == CMP_NONE)
                    && last_beat;
  assign t_rd_bus = take && is_data && !AP_WRITE && (beat_r == 3'h0);
  assign t_bar    = take && is_mbt && AP_WRITE;
  assign t_bus    = t_wr_bus || t_rd_bus || t_bar;
  assign t_local  = take && !t_bus && !t_cmp;

  assign bus_done   = (st_r == ST_BUS) && MEM_ACK;
  assign cmp_evt    = (st_r == ST_CMP) && MEM_ACK;
  // Find ends on a hit or once the count is spent
  assign cmp_finish = cmp_evt && (!find_r || match || (cnt_r == '0));
  assign reissue    = cmp_evt && !cmp_finish;

  // ---------------------------------------------------------------
  // Register read values
  // ---------------------------------------------------------------
  always_comb begin
    csw_rd = '0;
    csw_rd[ACCESS_SIZE_FIELD_LSB +: 3] = size_r;
    csw_rd[CSW_INC_LSB +: 2]  = inc_r;
    csw_rd[CSW_BUSY_BIT]      = st_r != ST_IDLE;
    csw_rd[CSW_MODE_LSB +: 4] = mode_r;
    cfg_rd = '0;
    cfg_rd[CFG_LA_BIT] = HAS_WIDE_ADDR;
    cfg_rd[CFG_LD_BIT] = HAS_WIDE_DATA;
  end

  always_comb begin
    if (AP_ADDR == OFF_CSW) begin
      reg_rd = csw_rd;
    end else if (AP_ADDR == OFF_TAR_LO) begin
      reg_rd = tar_r[31:0];
    end else if (AP_ADDR == OFF_TAR_HI) begin
      reg_rd = tar_r[63:32];
    end else if (AP_ADDR == OFF_TRR) begin
      reg_rd = {31'h0000_0000, trr_err_r};
    end else if (AP_ADDR == OFF_BASE_HI) begin
      reg_rd = HAS_WIDE_ADDR ? ROOT_HI : '0;
    end else if (AP_ADDR == OFF_CFG) begin
      reg_rd = cfg_rd;
    end else if (AP_ADDR == OFF_BASE_LO) begin
      reg_rd = ROOT_LO;
    end else if (AP_ADDR == OFF_IDR) begin
      reg_rd = IDENT;
    end else if (!is_data) begin
      reg_rd = '0;
    end else begin
      reg_rd = rbuf_r[{beat_r, 5'b00000} +: WORD_W];
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      st_r <= ST_IDLE;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (t_cmp) begin
            st_r <= ST_CMP;
          end else if (t_bus) begin
            st_r <= ST_BUS;
          end
        end
        ST_BUS: begin
          if (MEM_ACK) begin
            st_r <= ST_IDLE;
          end
        end
        ST_CMP: begin
          if (cmp_finish) begin
            st_r <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Control word and response
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      size_r <= SZ_WORD;
      inc_r  <= INC_OFF;
      mode_r <= MODE_RST;
    end else if (take && AP_WRITE && (AP_ADDR == OFF_CSW)) begin
      // Unsupported encodings fall back to word
      size_r <= SUP[AP_WDATA[ACCESS_SIZE_FIELD_LSB +: 3]]
                ? AP_WDATA[ACCESS_SIZE_FIELD_LSB +: 3] : SZ_WORD;
      inc_r  <= AP_WDATA[CSW_INC_LSB +: 2];
      mode_r <= HAS_BARRIER ? AP_WDATA[CSW_MODE_LSB +: 4] : MODE_RST;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      trr_err_r <= 1'b0;
    end else if ((bus_done || cmp_evt) && MEM_ERR) begin
      trr_err_r <= 1'b1;
    end else if (take && AP_WRITE && (AP_ADDR == OFF_TRR)
                 && AP_WDATA[TRR_ERR_BIT]) begin
      trr_err_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Transfer address
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      tar_r <= '0;
    end else if (take && AP_WRITE && (AP_ADDR == OFF_TAR_LO)) begin
      tar_r[31:0] <= AP_WDATA;
    end else if (take && AP_WRITE && (AP_ADDR == OFF_TAR_HI)) begin
      tar_r[63:32] <= HAS_WIDE_ADDR ? AP_WDATA : '0;
    end else if (bus_done && drw_r && !mem_bar_r) begin
      tar_r <= tar_r + tar_step;
    end else if (cmp_evt && !(find_r && match)) begin
      // Verify always steps; find steps on a miss only
      tar_r <= tar_r + tar_step;
    end
  end

  // ---------------------------------------------------------------
  // Wide beats and buffers
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      beat_r <= 3'h0;
    end else if (take && AP_WRITE && (AP_ADDR == OFF_CSW)) begin
      beat_r <= 3'h0;
    end else if (take && is_data && !t_cmp) begin
      beat_r <= last_beat ? 3'h0 : 3'(beat_r + 3'h1);
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      wbuf_r <= '0;
      rbuf_r <= '0;
    end else begin
      if (take && is_data && AP_WRITE && !t_cmp) begin
        wbuf_r <= wbuf_nxt;
      end
      if (bus_done && !mem_write_r) begin
        rbuf_r <= MEM_RDATA;
      end
    end
  end

  // ---------------------------------------------------------------
  // Compare operand and repeat count
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cmp_val_r  <= '0;
      cmp_mask_r <= '0;
      find_r     <= 1'b0;
      cnt_r      <= '0;
    end else if (t_cmp) begin
      cmp_val_r  <= AP_WDATA;
      cmp_mask_r <= (AP_CMP_MODE == CMP_FIND) ? lane_mask : '1;
      find_r     <= AP_CMP_MODE == CMP_FIND;
      cnt_r      <= REPEAT_COUNT;
    end else if (reissue) begin
      cnt_r <= cnt_r - CNT_ONE;
    end
  end

  // ---------------------------------------------------------------
  // Memory bus request
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      mem_req_r   <= 1'b0;
      mem_write_r <= 1'b0;
      mem_bar_r   <= 1'b0;
      mem_addr_r  <= '0;
      mem_wdata_r <= '0;
      drw_r       <= 1'b0;
    end else if (t_bus || t_cmp) begin
      mem_req_r   <= 1'b1;
      mem_write_r <= t_wr_bus;
      mem_bar_r   <= t_bar;
      mem_addr_r  <= t_bar ? tar_r : data_addr;
      mem_wdata_r <= wbuf_nxt;
      drw_r       <= is_drw;
    end else if (reissue) begin
      // Next counted read follows the stepped address
      mem_addr_r <= mem_addr_r + tar_step;
    end else if (MEM_ACK) begin
      mem_req_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Debug port answer
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ack_r     <= 1'b0;
      rdata_r   <= '0;
      cmp_set_r <= 1'b0;
      dec_r     <= 1'b0;
    end else begin
      ack_r     <= t_local || bus_done || cmp_finish;
      cmp_set_r <= cmp_evt && (find_r ? match : !match);
      dec_r     <= reissue;
      if (t_local && !AP_WRITE) begin
        rdata_r <= reg_rd;
      end else if (bus_done && !mem_write_r) begin
        rdata_r <= MEM_RDATA[WORD_W-1:0];
      end else if (t_cmp || t_bus) begin
        rdata_r <= '0;
      end
    end
  end

  assign AP_ACK      = ack_r;
  assign AP_RDATA    = rdata_r;
  assign CMP_SET     = cmp_set_r;
  assign REPEAT_DEC  = dec_r;
  assign MEM_REQ     = mem_req_r;
  assign MEM_WRITE   = mem_write_r;
  assign MEM_BARRIER = mem_bar_r;
  assign MEM_ADDR    = mem_addr_r;
  assign MEM_SIZE    = size_r;
  assign MEM_WDATA   = mem_wdata_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  a_size_legal: assert property (SUP[MEM_SIZE])
    else $error("bus size not supported");
  a_wide_split: assert property (
    take && is_data && AP_WRITE && AP_CMP_MODE == CMP_NONE && !last_beat
    |=> AP_ACK && !MEM_REQ) else $error("early wide bus write");
  a_barrier_req: assert property (t_bar |=> MEM_REQ && MEM_BARRIER)
    else $error("barrier not issued");
  a_verify_step: assert property (
    cmp_evt && !find_r |=> tar_r == $past(tar_r) + $past(tar_step))
    else $error("verify address not advanced");
  a_find_hit: assert property (
    cmp_evt && find_r && match
    |=> CMP_SET && st_r == ST_IDLE && tar_r == $past(tar_r))
    else $error("find hit mishandled");
  a_poll_fixed: assert property (
    cmp_evt && !inc_on |=> tar_r == $past(tar_r))
    else $error("poll address moved");
  a_count_dec: assert property (
    reissue |=> REPEAT_DEC && cnt_r == $past(cnt_r) - CNT_ONE
    ##1 MEM_REQ) else $error("repeat count not decremented");
  a_zero_stop: assert property (
    cmp_evt && find_r && cnt_r == '0 |=> st_r == ST_IDLE ##0 AP_ACK)
    else $error("search ran past zero count");
  a_rsv_zero: assert property (
    take && !AP_WRITE && !is_data && AP_ADDR > OFF_DAR_LAST
    && AP_ADDR < OFF_CSW |=> AP_ACK && AP_RDATA == '0)
    else $error("reserved read not zero");
  a_tar_narrow: assert property (
    !HAS_WIDE_ADDR |-> tar_r[63:32] == '0)
    else $error("upper address word not zero");

  c_find_hit:  cover property (cmp_evt && find_r && match);
  c_counted:   cover property (reissue ##1 reissue);
  c_wide_wr:   cover property (t_wr_bus && beat_r != 3'h0);
  c_barrier:   cover property (t_bar ##[1:8] bus_done);

endmodule // memory_access_port_core

// ---- sim/mem_bus_model.sv ----
`timescale 1ns/1ps
module mem_bus_model (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         req,
  input  wire logic         write,
  input  wire logic         barrier,
  input  wire logic [63:0]  addr,
  input  wire logic [2:0]   size,
  input  wire logic [255:0] wdata,
  input  wire logic [3:0]   delay,
  input  wire logic         err_en,
  output logic              ack,
  output logic [255:0]      rdata,
  output logic              err,
  output int                n_rd,
  output int                n_wr,
  output int                n_bar,
  output logic [2:0]        last_size,
  output logic [63:0]       last_addr,
  output logic [255:0]      last_wdata
);
  logic [3:0] wait_r;

  function automatic logic [255:0] line_of(input logic [31:0] a);
    for (int k = 0; k < 8; k++) begin
      line_of[32*k +: 32] = (a + 32'(4 * k)) ^ 32'h5A5A_0000;
    end
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack        <= 1'b0;
      err        <= 1'b0;
      rdata      <= '0;
      wait_r     <= 4'h0;
      n_rd       <= 0;
      n_wr       <= 0;
      n_bar      <= 0;
      last_size  <= 3'h0;
      last_addr  <= '0;
      last_wdata <= '0;
    end else if (ack || !req) begin
      // Released bus inverts its read data on every idle cycle
      ack    <= 1'b0;
      err    <= 1'b0;
      rdata  <= ~rdata;
      wait_r <= 4'h0;
    end else if (wait_r < delay) begin
      wait_r <= wait_r + 4'h1;
    end else begin
      ack       <= 1'b1;
      err       <= err_en;
      last_size <= size;
      last_addr <= addr;
      if (barrier) begin
        n_bar <= n_bar + 1;
      end else if (write) begin
        n_wr       <= n_wr + 1;
        last_wdata <= wdata;
      end else begin
        n_rd  <= n_rd + 1;
        rdata <= line_of(addr[31:0]);
      end
    end
  end
endmodule // mem_bus_model

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
  import memory_access_port_pkg::*;
;
  localparam logic [31:0] R_LO = 32'h1234_5003;
  localparam logic [31:0] R_HI = 32'h0000_00AB;
  // Arbitrary identification value
  localparam logic [31:0] ID   = 32'h0000_5A11;
  localparam logic [31:0] FULL = 32'hFFFF_FFFF;

  typedef struct {
    logic wr; logic [11:0] a; logic [31:0] d, msk, e, e2;
  } row_t;

  logic         CORE_CLK, RST, AP_REQ, AP_WRITE, AP_ACK, CMP_SET, REPEAT_DEC;
  logic         MEM_REQ, MEM_WRITE, MEM_BARRIER, MEM_ACK, MEM_ERR, err_en;
  logic [11:0]  AP_ADDR, REPEAT_COUNT;
  logic [31:0]  AP_WDATA, AP_RDATA, rdata_b, rd, rd_b;
  cmp_t         AP_CMP_MODE;
  logic [3:0]   AP_BYTE_MASK, mem_delay;
  logic [63:0]  MEM_ADDR, last_addr;
  logic [2:0]   MEM_SIZE, last_size;
  logic [255:0] MEM_WDATA, MEM_RDATA, last_wdata;
  int           n_rd, n_wr, n_bar, n_set, n_dec, k0, cycles;
  int           mismatches, total_checks;

  row_t rows [21] = '{
    '{0, OFF_CFG, 0, FULL, 32'h6, 32'h4},
    '{1, OFF_CFG, FULL, 0, 0, 0},
    '{0, OFF_CFG, 0, FULL, 32'h6, 32'h4},
    '{0, OFF_BASE_LO, 0, FULL, R_LO, R_LO},
    '{0, OFF_BASE_HI, 0, FULL, R_HI, 0},
    '{1, 12'h400, FULL, 0, 0, 0},
    '{0, 12'h400, 0, FULL, 0, 0},
    '{1, 12'hCFC, FULL, 0, 0, 0},
    '{0, 12'hCFC, 0, FULL, 0, 0},
    '{0, 12'hD28, 0, FULL, 0, 0},
    '{1, OFF_TAR_LO, 32'h1000, 0, 0, 0},
    '{1, OFF_TAR_HI, 32'h1, 0, 0, 0},
    '{0, OFF_TAR_LO, 0, FULL, 32'h1000, 32'h1000},
    '{0, OFF_TAR_HI, 0, FULL, 32'h1, 0},
    '{1, OFF_CSW, 32'h17, 0, 0, 0},
    '{0, OFF_CSW, 0, 32'hFF, 32'h12, 32'h12},
    '{1, OFF_CSW, 32'h16, 0, 0, 0},
    '{0, OFF_CSW, 0, 32'hFF, 32'h12, 32'h12},
    '{1, OFF_CSW, 32'h13, 0, 0, 0},
    '{0, OFF_CSW, 0, 32'hFF, 32'h13, 32'h13},
    '{0, OFF_IDR, 0, FULL, ID, ID}
  };

  memory_access_port_core #(.ROOT_LO(R_LO), .ROOT_HI(R_HI), .IDENT(ID))
    i_memory_access_port_core (.*);

  memory_access_port_core #(.HAS_WIDE_ADDR(1'b0), .HAS_BARRIER(1'b0),
    .ROOT_LO(R_LO), .ROOT_HI(R_HI), .IDENT(ID)) i_memory_access_port_core_b (
    .CORE_CLK, .RST, .AP_REQ, .AP_WRITE, .AP_ADDR, .AP_WDATA, .AP_CMP_MODE,
    .AP_BYTE_MASK, .REPEAT_COUNT, .AP_ACK(), .AP_RDATA(rdata_b),
    .CMP_SET(), .REPEAT_DEC(), .MEM_REQ(), .MEM_WRITE(), .MEM_BARRIER(),
    .MEM_ADDR(), .MEM_SIZE(), .MEM_WDATA(), .MEM_RDATA, .MEM_ACK, .MEM_ERR);

  mem_bus_model i_mem_bus_model (.clk(CORE_CLK), .rst(RST), .req(MEM_REQ),
    .write(MEM_WRITE), .barrier(MEM_BARRIER), .addr(MEM_ADDR),
    .size(MEM_SIZE), .wdata(MEM_WDATA), .delay(mem_delay), .err_en(err_en),
    .ack(MEM_ACK), .rdata(MEM_RDATA), .err(MEM_ERR), .n_rd(n_rd),
    .n_wr(n_wr), .n_bar(n_bar), .last_size(last_size),
    .last_addr(last_addr), .last_wdata(last_wdata));

  function automatic logic [31:0] pat(input logic [31:0] a);
    return a ^ 32'h5A5A_0000;
  endfunction

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until the acknowledge is sampled
  task automatic ap(input logic wr, input logic [11:0] a,
                    input logic [31:0] d, input cmp_t m = CMP_NONE,
                    input logic [3:0] bm = 4'hF, input logic [11:0] n = 0);
    int k;
    @(posedge CORE_CLK);
    AP_REQ       <= 1'b1;
    AP_WRITE     <= wr;
    AP_ADDR      <= a;
    AP_WDATA     <= d;
    AP_CMP_MODE  <= m;
    AP_BYTE_MASK <= bm;
    REPEAT_COUNT <= n;
    k = 0;
    n_set = 0;
    n_dec = 0;
    do begin
      @(posedge CORE_CLK);
      k++;
      n_set += int'(CMP_SET === 1'b1);
      n_dec += int'(REPEAT_DEC === 1'b1);
    end while (AP_ACK !== 1'b1 && k < 300);
    rd = AP_RDATA;
    rd_b = rdata_b;
    AP_REQ <= 1'b0;
    chk(64'(k < 300), 64'h1);
  endtask

  task automatic tar_is(input logic [31:0] e);
    ap(0, OFF_TAR_LO, 0);
    chk(rd, e);
  endtask

  // ---------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------
  initial begin
    CORE_CLK = 1'b0;
    forever #25 CORE_CLK = ~CORE_CLK;
  end

  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  initial begin
    {RST, AP_REQ, AP_WRITE, AP_ADDR, AP_WDATA} = {1'b1, 46'h0};
    {AP_BYTE_MASK, REPEAT_COUNT, mem_delay, err_en} = 21'h0;
    AP_CMP_MODE = CMP_NONE;
    {cycles, mismatches, total_checks} = 0;
    repeat (2) @(posedge CORE_CLK);
    RST <= 1'b0;
    foreach (rows[i]) begin
      ap(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) begin
        chk(rd & rows[i].msk, rows[i].e);
        chk(rd_b & rows[i].msk, rows[i].e2);
      end
    end
    ap(0, OFF_MBT, 0);
    chk(rd_b, 0);
    mem_delay <= 4'h3;
    ap(1, OFF_TAR_HI, 0);
    ap(1, OFF_TAR_LO, 32'h2000);
    k0 = n_rd;
    ap(0, OFF_DRW, 0);
    chk(rd, pat(32'h2000));
    ap(0, OFF_DRW, 0);
    chk(rd, pat(32'h2004));
    chk(n_rd - k0, 1);
    chk(last_size, SZ_DWORD);
    ap(1, OFF_TAR_HI, 1);
    ap(1, OFF_CSW, 32'h17);
    chk(MEM_SIZE, SZ_WORD);
    ap(0, OFF_DRW, 0);
    chk(last_size, SZ_WORD);
    chk(last_addr, 64'h1_0000_2008);
    ap(1, OFF_TAR_HI, 0);
    ap(1, OFF_CSW, 32'h14);
    k0 = n_wr;
    for (int k = 0; k < 4; k++) ap(1, OFF_DRW, 32'hC0DE_0000 + k);
    chk(n_wr - k0, 1);
    chk(last_wdata[63:0] ^ {2{32'hC0DE_0000}}, 64'h1_0000_0000);
    chk(last_wdata[127:64] ^ {2{32'hC0DE_0000}}, 64'h3_0000_0002);
    mem_delay <= 4'h0;
    ap(1, OFF_CSW, 32'h12);
    ap(1, OFF_TAR_LO, 32'h4000);
    k0 = n_wr;
    ap(1, OFF_DRW, pat(32'h4000), CMP_VERIFY);
    chk(n_set, 0);
    ap(1, OFF_DRW, 0, CMP_VERIFY);
    chk(n_set, 1);
    chk(n_wr - k0, 0);
    tar_is(32'h4008);
    ap(1, OFF_TAR_LO, 32'h5000);
    ap(1, OFF_DRW, pat(32'h5000) ^ 32'hFF00_0000, CMP_FIND, 4'h7);
    chk(n_set, 1);
    tar_is(32'h5000);
    ap(1, OFF_DRW, pat(32'h5000) ^ 32'hFF00_0000, CMP_FIND, 4'hF);
    chk(n_set, 0);
    tar_is(32'h5004);
    ap(1, OFF_CSW, 32'h02);
    ap(1, OFF_DRW, 0, CMP_FIND);
    ap(1, OFF_DRW, 0, CMP_FIND);
    chk(last_addr, 64'h5004);
    tar_is(32'h5004);
    ap(1, OFF_CSW, 32'h12);
    ap(1, OFF_TAR_LO, 32'h6000);
    k0 = n_rd;
    ap(1, OFF_DRW, pat(32'h6008), CMP_FIND, 4'hF, 12'h003);
    chk(n_set, 1);
    chk(n_dec, 2);
    chk(n_rd - k0, 3);
    tar_is(32'h6008);
    ap(1, OFF_TAR_LO, 32'h6000);
    k0 = n_rd;
    ap(1, OFF_DRW, 0, CMP_FIND, 4'hF, 12'h002);
    chk(n_set, 0);
    chk(n_dec, 2);
    chk(n_rd - k0, 3);
    tar_is(32'h600C);
    k0 = n_bar;
    ap(1, OFF_MBT, 0);
    chk(n_bar - k0, 1);
    err_en <= 1'b1;
    ap(0, OFF_DRW, 0);
    err_en <= 1'b0;
    ap(0, OFF_TRR, 0);
    chk(rd[0], 1);
    ap(1, OFF_TRR, 1);
    ap(0, OFF_TRR, 0);
    chk(rd[0], 0);
    // Non-word size so the reset value is visible
    ap(1, OFF_CSW, 32'h13);
    @(posedge CORE_CLK);
    RST <= 1'b1;
    @(posedge CORE_CLK);
    @(posedge CORE_CLK);
    chk({MEM_SIZE, AP_ACK, MEM_REQ}, {SZ_WORD, 2'b00});
    RST <= 1'b0;
    ap(0, OFF_CSW, 0);
    chk(rd & 32'h7, 32'h2);
    end_sim();
  end
endmodule // tb_top
